// >>> vpwm_autoscale.sv
`timescale 1ns/100ps
`default_nettype none
module vpwm_autoscale
    import vpwm_pkg::*;
#(
    parameter int STILL_CYCLES = STILL_CYC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_step,
    input wire logic i_driver_enable_n,
    input wire logic i_mode_pin,
    input wire logic i_blank_time_select_pin,
    input wire logic i_short_det,
    input wire logic [7:0] i_coil_cur,
    output logic o_coil_a_pwm,
    output logic o_coil_b_pwm,
    output logic o_irq
);
    // Pin synchronisers: step, enable, mode, blank, short
    logic [4:0] pin_raw;
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    assign pin_raw = {i_short_det, i_blank_time_select_pin, i_mode_pin,
        i_driver_enable_n, i_step};
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_sync
            always_ff @(posedge I_SYS_CLK) begin
                if (I_SYS_RST) begin
                    meta_r[g] <= (g == 1);
                    sync_r[g] <= (g == 1);
                end else begin
                    meta_r[g] <= pin_raw[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    logic step_d_r;
    logic step_edge;
    logic enabled;
    assign step_edge = sync_r[0] & ~step_d_r;
    assign enabled = ~sync_r[1];

    // PWM timebase
    logic per_start;
    logic [8:0] phase;
    pwm_period_gen u_per (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .o_start(per_start),
        .o_phase(phase)
    );

    // Filtered configuration pins
    logic mode_alt;
    logic mode_chg;
    logic blank_sel;
    cfg_pin_filter u_mode (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_level(sync_r[2]),
        .o_value(mode_alt),
        .o_changed(mode_chg)
    );
    cfg_pin_filter u_blank (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_level(sync_r[3]),
        .o_value(blank_sel),
        .o_changed()
    );

    logic [8:0] blank_time_setting;
    assign blank_time_setting = blank_sel ? BLANK_LONG : BLANK_SHORT;

    // Registers and regulator state
    logic [7:0] target_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [7:0] ampl_r;
    logic [7:0] sample_r;
    logic sample_vld_r;
    logic settled_r;
    logic [7:0] settle_cnt_r;
    logic fault_r;
    logic [17:0] still_cnt_r;
    logic still_r;
    logic [3:0] ustep_r;
    logic fstep_r;
    logic quiet;
    logic [8:0] on_time;
    logic observable;
    logic reg_tick;
    logic stuck;
    assign quiet = enabled & ~mode_alt & ~fault_r;
    assign on_time = {ampl_r, 1'b0};
    // On-time shorter than blanking cannot be measured
    assign observable = on_time > blank_time_setting;

    // Step edge, fullstep and standstill tracking
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            step_d_r <= 1'b0;
            ustep_r <= 4'h0;
            fstep_r <= 1'b0;
            still_cnt_r <= 18'h00000;
            still_r <= 1'b1;
        end else begin
            step_d_r <= sync_r[0];
            fstep_r <= step_edge && (ustep_r == USTEP_LAST);
            if (step_edge) begin
                ustep_r <= ustep_r + 4'h1;
                still_cnt_r <= 18'h00000;
                still_r <= 1'b0;
            end else if (still_cnt_r == 18'(STILL_CYCLES - 1)) begin
                still_r <= 1'b1;
            end else begin
                still_cnt_r <= still_cnt_r + 18'h00001;
            end
        end
    end

    // Current is only seen through the shunt after blanking in the on phase
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            sample_r <= 8'h00;
            sample_vld_r <= 1'b0;
        end else if (!quiet) begin
            sample_vld_r <= 1'b0;
        end else if (observable && phase == blank_time_setting) begin
            sample_r <= i_coil_cur;
            sample_vld_r <= 1'b1;
        end else if (reg_tick) begin
            sample_vld_r <= 1'b0;
        end
    end

    // Moving: once per fullstep; standstill: once per period
    assign reg_tick = quiet && sample_vld_r && (still_r ? per_start : fstep_r);
    // Below the floor nothing can be measured while moving
    assign stuck = quiet && !observable && !still_r;

    // Bounded proportional correction
    logic signed [9:0] err;
    logic signed [9:0] corr;
    logic signed [9:0] sum;
    always_comb begin
        err = $signed({2'b00, target_r}) - $signed({2'b00, sample_r});
        corr = err >>> GAIN_SHIFT;
        if (corr > MAX_CORR) begin
            corr = MAX_CORR;
        end else if (corr < -MAX_CORR) begin
            corr = -MAX_CORR;
        end
        sum = $signed({2'b00, ampl_r}) + corr;
    end

    // Amplitude survives the other mode; a new enable starts from zero
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST || !enabled) begin
            ampl_r <= 8'h00;
        end else if (!quiet) begin
            ampl_r <= ampl_r;
        end else if (!settled_r && !still_r) begin
            ampl_r <= ampl_r;
        end else if (still_r && !observable && per_start) begin
            ampl_r <= ampl_r + 8'(MAX_CORR);
        end else if (reg_tick) begin
            if (sum < 10'sh000) begin
                ampl_r <= 8'h00;
            end else if (sum > 10'sh0ff) begin
                ampl_r <= 8'hff;
            end else begin
                ampl_r <= sum[7:0];
            end
        end
    end

    // Initial standstill settling over 128 periods
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST || !enabled) begin
            settle_cnt_r <= 8'h00;
            settled_r <= 1'b0;
        end else if (quiet && still_r && per_start && !settled_r) begin
            if (settle_cnt_r == SETTLE_PERIODS - 8'h01) begin
                settled_r <= 1'b1;
            end
            settle_cnt_r <= settle_cnt_r + 8'h01;
        end
    end

    // Short latches until the enable pin is cycled
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST || !enabled) begin
            fault_r <= 1'b0;
        end else if (sync_r[4]) begin
            fault_r <= 1'b1;
        end
    end

    // Voltage-mode duty, both coils share the amplitude
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_coil_a_pwm <= 1'b0;
            o_coil_b_pwm <= 1'b0;
        end else begin
            o_coil_a_pwm <= quiet && (phase < on_time);
            o_coil_b_pwm <= quiet && (phase < on_time);
        end
    end

    // Wishbone classic slave, one wait state
    logic wb_req;
    logic wb_wr;
    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wb_wr = wb_req && i_wb_we;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            OFS_CTRL: rd_mux = {24'h000000, target_r};
            OFS_STAT: rd_mux = {19'h00000, blank_sel, fault_r, still_r,
                settled_r, quiet, ampl_r};
            OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_r};
            OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_r};
            OFS_SAMPLE: rd_mux = {24'h000000, sample_r};
            default: rd_mux = 32'h00000000;
        endcase
    endfunction : rd_mux

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= wb_req ? rd_mux(i_wb_adr) : 32'h00000000;
        end
    end

    // Software writes: target current and mask
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            target_r <= CTRL_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wb_wr && i_wb_sel[0]) begin
            if (i_wb_adr == OFS_CTRL) begin
                target_r <= i_wb_dat[7:0];
            end
            if (i_wb_adr == OFS_IRQ_MASK) begin
                irq_mask_r <= i_wb_dat[3:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event wins
    logic [3:0] ev;
    logic [3:0] clr;
    logic settled_d_r;
    assign ev = {stuck, mode_chg, settled_r & ~settled_d_r, sync_r[4] & ~fault_r};
    assign clr = (wb_wr && i_wb_sel[0] && i_wb_adr == OFS_IRQ_STAT) ? i_wb_dat[3:0] : 4'h0;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            irq_stat_r <= 4'h0;
            settled_d_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            settled_d_r <= settled_r;
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
            o_irq <= |(((irq_stat_r & ~clr) | ev) & irq_mask_r);
        end
    end

    // Checks
    property p_sample_on;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $rose(sample_vld_r) |-> $past(phase) < $past(on_time);
    endproperty
    a_sample_on: assert property (p_sample_on) else $error("sample outside on phase");

    property p_bound;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $past(enabled) && enabled && $past(ampl_r) <= 8'hf0 |->
        ampl_r <= $past(ampl_r) + 8'h04;
    endproperty
    a_bound: assert property (p_bound) else $error("correction too large");

    property p_init_still;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $past(enabled) && !settled_r && !$past(still_r) |-> $stable(ampl_r);
    endproperty
    a_init_still: assert property (p_init_still) else $error("initial regulation moving");

    property p_hold_alt;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $past(enabled) && $past(mode_alt) && enabled |-> $stable(ampl_r);
    endproperty
    a_hold_alt: assert property (p_hold_alt) else $error("amplitude lost in other mode");

    property p_floor;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $rose(sample_vld_r) |-> $past(on_time) > $past(blank_time_setting);
    endproperty
    a_floor: assert property (p_floor) else $error("sampled below duty floor");

    property p_fault;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        sync_r[4] && enabled |=> fault_r ##1 !o_coil_a_pwm;
    endproperty
    a_fault: assert property (p_fault) else $error("short not latched");

    property p_quiet_pwm;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !quiet |=> !o_coil_a_pwm && !o_coil_b_pwm;
    endproperty
    a_quiet_pwm: assert property (p_quiet_pwm) else $error("drive outside quiet mode");

    property p_ack;
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule : vpwm_autoscale
`default_nettype wire

// >>> vpwm_pkg.sv
// What this block does
// - PWM rate is 2/683 of clock
// - Quiet mode sets current through duty amplitude
// - Sample current in on phase, proportional loop
// - One measurement per fullstep while moving, one per period at standstill, bounded correction
// - Initial regulation only at standstill
// - Blank time and PWM rate bound minimum duty
// - Blank time selectable, shorter lowers floor
// - Stuck while moving, recovers at standstill
// - Mode pin change filtered for 3072 clocks
// - Keep last amplitude while other mode runs
// - Short flagged, regulator may stick low
package vpwm_pkg;
    localparam int CLK_MHZ = 250;
    // Period pair of 683 clocks gives two PWM periods
    localparam logic [8:0] PER_SHORT = 9'h155;
    localparam logic [8:0] PER_LONG = 9'h156;
    // Tristate pin detection filter
    localparam logic [11:0] MODE_FILT_CYC = 12'hc00;
    // Standstill after no step for this long
    localparam int STILL_TIME_US = 1000;
    localparam int STILL_CYC = STILL_TIME_US * CLK_MHZ;
    // Initial settling, in PWM periods
    localparam logic [7:0] SETTLE_PERIODS = 8'h80;
    // Last microstep index of a fullstep (16 microsteps per fullstep)
    localparam logic [3:0] USTEP_LAST = 4'hf;
    // Blank times in clocks, selected by the blank pin
    localparam logic [8:0] BLANK_SHORT = 9'h010;
    localparam logic [8:0] BLANK_LONG = 9'h018;
    // Regulator gain shift and correction bound
    localparam int GAIN_SHIFT = 2;
    localparam logic signed [9:0] MAX_CORR = 10'sh004;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SAMPLE = 8'h10;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // Interrupt bit positions
    localparam int IRQ_SHORT = 0;
    localparam int IRQ_SETTLED = 1;
    localparam int IRQ_MODE = 2;
    localparam int IRQ_STUCK = 3;
    // Status bit positions
    localparam int ST_QUIET = 8;
    localparam int ST_SETTLED = 9;
    localparam int ST_STILL = 10;
    localparam int ST_FAULT = 11;
    localparam int ST_BLANK = 12;
endpackage : vpwm_pkg

// >>> pwm_period_gen.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_period_gen
    import vpwm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    output logic o_start,
    output logic [8:0] o_phase
);
    logic long_r;
    logic [8:0] cnt_r;
    logic [8:0] last;

    assign last = long_r ? PER_LONG - 9'h001 : PER_SHORT - 9'h001;
    assign o_phase = cnt_r;
    assign o_start = (cnt_r == 9'h000);

    // Alternating lengths keep the pair exactly 683 clocks
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 9'h000;
            long_r <= 1'b0;
        end else if (cnt_r == last) begin
            cnt_r <= 9'h000;
            long_r <= ~long_r;
        end else begin
            cnt_r <= cnt_r + 9'h001;
        end
    end

    // Short period must hand over to a long one
    property p_pair;
        @(posedge i_clk) disable iff (i_rst)
        (cnt_r == PER_SHORT - 9'h001) && !long_r |=> (cnt_r == 9'h000) && long_r;
    endproperty
    a_pair: assert property (p_pair) else $error("short period length wrong");

    // Long period must hand back to a short one
    property p_pair_long;
        @(posedge i_clk) disable iff (i_rst)
        (cnt_r == PER_LONG - 9'h001) && long_r |=> (cnt_r == 9'h000) && !long_r;
    endproperty
    a_pair_long: assert property (p_pair_long) else $error("long period length wrong");
endmodule : pwm_period_gen
`default_nettype wire

// >>> cfg_pin_filter.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_pin_filter
    import vpwm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_value,
    output logic o_changed
);
    logic [11:0] cnt_r;
    logic val_r;
    logic chg_r;

    assign o_value = val_r;
    assign o_changed = chg_r;

    // New level only taken after it has held for the whole window
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 12'h000;
            val_r <= 1'b0;
            chg_r <= 1'b0;
        end else begin
            chg_r <= 1'b0;
            if (i_level == val_r) begin
                cnt_r <= 12'h000;
            end else if (cnt_r == MODE_FILT_CYC - 12'h001) begin
                val_r <= i_level;
                chg_r <= 1'b1;
                cnt_r <= 12'h000;
            end else begin
                cnt_r <= cnt_r + 12'h001;
            end
        end
    end

    property p_filt;
        @(posedge i_clk) disable iff (i_rst)
        $changed(val_r) |-> $past(cnt_r) == MODE_FILT_CYC - 12'h001;
    endproperty
    a_filt: assert property (p_filt) else $error("filter took level early");
endmodule : cfg_pin_filter
`default_nettype wire

// >>> coil_model.sv
`timescale 1ns/100ps
`default_nettype none
module coil_model (
    input wire logic i_clk,
    input wire logic i_coil_pwm,
    output logic [7:0] o_coil_cur
);
    logic [9:0] win_r;
    logic [10:0] high_r;

    initial begin
        win_r = 10'h000;
        high_r = 11'h000;
        o_coil_cur = 8'h00;
    end

    // Current follows mean on-time; a window of two periods hides the 341/342 split
    // Falls to zero within two windows when the drive stops, so no stale value lingers
    always @(posedge i_clk) begin
        if (win_r == 10'h2aa) begin
            win_r <= 10'h000;
            o_coil_cur <= (high_r > 11'h1fe) ? 8'hff : 8'(high_r >> 1);
            high_r <= 11'(i_coil_pwm);
        end else begin
            win_r <= win_r + 10'h001;
            high_r <= high_r + 11'(i_coil_pwm);
        end
    end
endmodule : coil_model
`default_nettype wire

// >>> voltage_pwm_current_autoscale_test.sv
`timescale 1ns/100ps
`default_nettype none
module voltage_pwm_current_autoscale_test;
    import vpwm_pkg::*;
    localparam int STILL_SIM = 200;
    typedef struct packed { logic [31:0] val; logic [31:0] msk; } note_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic step_pin = 1'b0;
    logic drv_en_n = 1'b1;
    logic mode_pin = 1'b0;
    logic blank_pin = 1'b0;
    logic short_pin = 1'b0;
    logic [7:0] coil_cur;
    logic pwm_a;
    logic pwm_b;
    logic irq;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 70;
    int cyc_cnt = 0;
    note_t notes[$];
    logic [31:0] rd_val;
    logic [7:0] a0;
    int t0, t1, t2, h, i;

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc_cnt <= cyc_cnt + 1;

    vpwm_autoscale #(.STILL_CYCLES(STILL_SIM)) dut (
        .I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat_w),
        .i_wb_sel(wb_sel), .i_wb_we(wb_we), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .o_wb_dat(wb_dat_r), .o_wb_ack(wb_ack), .i_step(step_pin),
        .i_driver_enable_n(drv_en_n), .i_mode_pin(mode_pin),
        .i_blank_time_select_pin(blank_pin), .i_short_det(short_pin),
        .i_coil_cur(coil_cur), .o_coil_a_pwm(pwm_a), .o_coil_b_pwm(pwm_b), .o_irq(irq)
    );

    coil_model coil (.i_clk(sys_clk), .i_coil_pwm(pwm_a), .o_coil_cur(coil_cur));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                           input logic [3:0] sel);
        wb_adr <= adr;
        wb_we <= we;
        wb_dat_w <= dat;
        wb_sel <= sel;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        @(posedge sys_clk);
        while (wb_ack !== 1'b1) @(posedge sys_clk);
        rd_val = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb_xfer

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(adr, 1'b1, dat, 4'hf);
    endtask : wb_wr

    task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        notes.push_back({exp, msk});
        wb_xfer(adr, 1'b0, 32'h0000_0000, 4'hf);
    endtask : wb_rd

    // Read answers are matched against the oldest note
    always @(posedge sys_clk) begin
        if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
            check(wb_dat_r & notes[0].msk, notes[0].val & notes[0].msk);
            void'(notes.pop_front());
        end
    end

    function automatic logic [31:0] inr(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        return {31'h0, (v >= lo) && (v <= hi)};
    endfunction : inr

    task automatic next_rise(output int t);
        int k;
        k = 0;
        while (pwm_a !== 1'b0 && k < 1000) begin
            @(posedge sys_clk);
            k++;
        end
        while (pwm_a !== 1'b1 && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        t = cyc_cnt;
    endtask : next_rise

    task automatic hi_count(input int n, output int hc);
        hc = 0;
        repeat (n) begin
            @(posedge sys_clk);
            hc += (pwm_a !== 1'b0 || pwm_b !== 1'b0) ? 1 : 0;
        end
    endtask : hi_count

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog sized for about 70k cycles of tests
    initial begin
        repeat (95000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        // Reset values, unmapped place, byte lane 0 gating
        wb_rd(OFS_CTRL, 32'h0000_0040, 32'h0000_00ff);
        wb_rd(OFS_IRQ_MASK, 32'h0000_0000, 32'h0000_000f);
        wb_wr(8'h14, 32'hffff_ffff);
        wb_rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
        wb_xfer(OFS_CTRL, 1'b1, 32'h0000_0055, 4'he);
        wb_rd(OFS_CTRL, 32'h0000_0040, 32'h0000_00ff);
        wb_rd(OFS_STAT, 32'h0000_0000, 32'h0000_1bff);
        // Enable and keep still until the first regulation settles
        drv_en_n <= 1'b0;
        repeat (120 * 342) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0000, 32'h0000_0200);
        repeat (8 * 342 + STILL_SIM + 400) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0200, 32'h0000_0a00);
        check(inr(rd_val[7:0], 8'h1c, 8'h24), 32'h1);
        check({31'h0, irq}, 32'h0);
        wb_rd(OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
        wb_wr(OFS_IRQ_MASK, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        wb_wr(OFS_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        // Period pair of 683 clocks
        next_rise(t0);
        next_rise(t1);
        next_rise(t2);
        check(32'(t2 - t0), 32'h0000_02ab);
        check({31'h0, (t1 - t0 == 341) || (t1 - t0 == 342)}, 32'h1);
        // Raised target: bounded step per update
        wb_wr(OFS_CTRL, 32'h0000_0080);
        wb_rd(OFS_STAT, 32'h0, 32'h0);
        a0 = rd_val[7:0];
        for (i = 0; i < 4; i++) begin
            next_rise(t0);
            wb_rd(OFS_STAT, 32'h0, 32'h0);
            check(inr(rd_val[7:0] - a0, 8'h00, 8'h04), 32'h1);
            a0 = rd_val[7:0];
        end
        repeat (20 * 342) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0, 32'h0);
        check(inr(rd_val[7:0], 8'h3a, 8'h44), 32'h1);
        // Motion with random step spacing, regulation holds
        for (i = 0; i < 48; i++) begin
            step_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            step_pin <= 1'b0;
            repeat (20 + ($unsigned($random(seed)) % 64)) @(posedge sys_clk);
        end
        wb_rd(OFS_STAT, 32'h0, 32'h0);
        check(inr(rd_val[7:0], 8'h36, 8'h48), 32'h1);
        repeat (STILL_SIM + 100) @(posedge sys_clk);
        // Blank select pin passes the 3072 clock filter
        blank_pin <= 1'b1;
        repeat (3000) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0000, 32'h0000_1000);
        repeat (200) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_1000, 32'h0000_1000);
        // Other mode keeps the amplitude and stops the drive
        wb_rd(OFS_STAT, 32'h0, 32'h0);
        a0 = rd_val[7:0];
        mode_pin <= 1'b1;
        repeat (3000) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0100, 32'h0000_0100);
        repeat (200) @(posedge sys_clk);
        wb_rd(OFS_STAT, {24'h0, a0}, 32'h0000_01ff);
        hi_count(400, h);
        check(32'(h), 32'h0);
        wb_rd(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
        mode_pin <= 1'b0;
        repeat (3200) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0100, 32'h0000_0100);
        // Short latches a fault until the enable pin cycles
        wb_wr(OFS_IRQ_MASK, 32'h0000_0001);
        short_pin <= 1'b1;
        repeat (5) @(posedge sys_clk);
        short_pin <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        wb_rd(OFS_STAT, 32'h0000_0800, 32'h0000_0800);
        hi_count(400, h);
        check(32'(h), 32'h0);
        drv_en_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0000_0000, 32'h0000_08ff);
        drv_en_n <= 1'b0;
        repeat (10 * 342) @(posedge sys_clk);
        wb_rd(OFS_STAT, 32'h0, 32'h0);
        check({31'h0, rd_val[7:0] != 8'h00}, 32'h1);
        wb_wr(OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule : voltage_pwm_current_autoscale_test
`default_nettype wire
